// *** flt_pkg.sv ***
// Constants, register map and state types for the flight-time and temperature
// measurement sequencer. Assumes a 50 MHz system clock and a 4 MHz timing reference.
package flt_pkg;
	// ----------------------------------------------------------------
	// Clocking and fixed-point time base
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int REF_HZ = 4_000_000;
	// Reference period in 16.16 fixed point gained per system clock.
	localparam logic [31:0] FX_STEP = 32'((64'd65536 * REF_HZ) / CLK_HZ);
	localparam int CHARGE_NS = 16000;
	localparam int CHARGE_CYC = (CHARGE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int PORT_BASE_NS = 64000;
	localparam int PORT_BASE_CYC = (PORT_BASE_NS * (CLK_HZ / 1_000_000)) / 1000;
	localparam int DIV_W = 40;
	localparam int RAT_FRAC = 7;
	localparam int DM_SHIFT = 2;
	localparam logic [16:0] LIM_BASE = 17'h00100;
	localparam logic [15:0] ALL1 = 16'hffff;
	localparam logic [15:0] DIFF_ERR = 16'h7fff;
	localparam logic [15:0] RST16 = 16'h0000;
	// ----------------------------------------------------------------
	// Register addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] A_CMD = 8'h00;
	localparam logic [7:0] A_HITCFG = 8'h01;
	localparam logic [7:0] A_WSA = 8'h02;
	localparam logic [7:0] A_WSB = 8'h03;
	localparam logic [7:0] A_WSC = 8'h04;
	localparam logic [7:0] A_OFSU = 8'h05;
	localparam logic [7:0] A_OFSD = 8'h06;
	localparam logic [7:0] A_LAUNCH = 8'h07;
	localparam logic [7:0] A_TEMPCFG = 8'h08;
	localparam logic [7:0] A_INTEN = 8'h09;
	localparam logic [7:0] A_INTST = 8'h0a;
	localparam logic [7:0] A_UPHIT = 8'h10;
	localparam logic [7:0] A_DNHIT = 8'h20;
	localparam logic [7:0] A_MEAN = 8'h30;
	localparam logic [7:0] A_RATIO = 8'h34;
	localparam logic [7:0] A_DELTA = 8'h36;
	localparam logic [7:0] A_DMEAN = 8'h38;
	localparam logic [7:0] A_PORT = 8'h40;
	// ----------------------------------------------------------------
	// Field positions and codes
	// ----------------------------------------------------------------
	localparam int HC_T2W = 0;
	localparam int HC_NH = 6;
	localparam int HC_LIM = 9;
	localparam int WS_HI = 8;
	localparam int OF_EARLY = 0;
	localparam int OF_POL = 7;
	localparam int OF_RET = 8;
	localparam int LC_DLY = 0;
	localparam int LC_IDEAL = 8;
	localparam int TC_PORT = 0;
	localparam int TC_DUM = 2;
	localparam int TC_IVL = 5;
	localparam int IB_FLIGHT = 0;
	localparam int IB_TOUT = 1;
	localparam int IB_THERM = 2;
	localparam logic [2:0] CMD_UP = 3'h1;
	localparam logic [2:0] CMD_DN = 3'h2;
	localparam logic [2:0] CMD_DIFF = 3'h3;
	localparam logic [2:0] CMD_TEMP = 3'h4;
	typedef enum logic [2:0] {S_IDLE, S_DELAY, S_EARLY, S_T1, S_WAVES, S_DIV, S_COMMIT} flt_tof_t;
	typedef enum logic [1:0] {T_IDLE, T_CHG, T_DIS, T_GAP} flt_tmp_t;
endpackage

// *** flt_seq.sv ***
// Flight-time measurement tail and temperature port sequencer.
// Assumes comparator outputs and the capacitor comparator arrive asynchronously,
// and that the launch driver starts its burst on o_launch_go.
`timescale 1ns/10ps
module flt_seq import flt_pkg::*; #(
	parameter int HITS = 6
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// Register port
	input wire logic [7:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	// Receive side
	input wire logic i_stop_up,
	input wire logic i_stop_dn,
	output logic o_launch_go,
	output logic o_launch_dn,
	output logic o_cmp_en_up,
	output logic o_cmp_en_dn,
	output logic [7:0] o_cmp_offset,
	// Temperature side
	input wire logic i_cap_cmp,
	output logic o_cap_o,
	output logic o_cap_oe_n,
	output logic [3:0] o_probe_o,
	output logic [3:0] o_probe_oe_n,
	output logic o_emul_en,
	// Interrupt
	output logic o_int_n
);
	// ----------------------------------------------------------------
	// Synchronisers and configuration
	// ----------------------------------------------------------------
	logic [2:0] s1_r, s2_r;
	logic [15:0] hit_cfg_r, launch_r, tcfg_r;
	logic [15:0] ws_r [0:2];
	logic [15:0] ofs_r [0:1];
	logic [2:0] inten_r, st_r, st_nxt;
	flt_tof_t st;
	flt_tmp_t tst;
	logic dir_r, diff_r, err_r, uperr_r, lvl_q_r, t2on_r, t2done_r, dld_r;
	logic [31:0] el_r, t1_r, t2_r, avg_r;
	logic [31:0] sh_hit_r [0:HITS-1];
	logic [34:0] sum_r;
	logic [5:0] wave_r, dcnt_r;
	logic [2:0] hidx_r;
	logic [1:0] job_r;
	logic [DIV_W-1:0] num_r;
	logic [31:0] den_r, rem_r;
	logic [7:0] r1_r, r2_r;

	// Pins cross into the clock domain through two flops.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			s1_r <= 3'h0;
			s2_r <= 3'h0;
		end else begin
			s1_r <= {i_cap_cmp, i_stop_dn, i_stop_up};
			s2_r <= s1_r;
		end
	end

	// Software-written configuration.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			hit_cfg_r <= RST16;
			launch_r <= RST16;
			tcfg_r <= RST16;
			inten_r <= 3'h0;
			for (int i = 0; i < 3; i++) ws_r[i] <= RST16;
			for (int i = 0; i < 2; i++) ofs_r[i] <= RST16;
		end else if (i_wr) begin
			case (i_addr)
				A_HITCFG: hit_cfg_r <= i_wdata;
				A_WSA: ws_r[0] <= i_wdata;
				A_WSB: ws_r[1] <= i_wdata;
				A_WSC: ws_r[2] <= i_wdata;
				A_OFSU: ofs_r[0] <= i_wdata;
				A_OFSD: ofs_r[1] <= i_wdata;
				A_LAUNCH: launch_r <= i_wdata;
				A_TEMPCFG: tcfg_r <= i_wdata;
				A_INTEN: inten_r <= i_wdata[2:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Flight-time decode
	// ----------------------------------------------------------------
	wire cmd_wr = i_wr && i_addr == A_CMD;
	wire [2:0] cmd = i_wdata[2:0];
	wire tof_go = cmd_wr && st == S_IDLE && (cmd == CMD_UP || cmd == CMD_DN || cmd == CMD_DIFF);
	wire [5:0] t2sel = hit_cfg_r[HC_T2W +: 6];
	wire [2:0] nh_raw = hit_cfg_r[HC_NH +: 3];
	wire [2:0] nh = (nh_raw == 3'h0) ? 3'h1 : (nh_raw > 3'(HITS)) ? 3'(HITS) : nh_raw;
	wire [16:0] lim = LIM_BASE << hit_cfg_r[HC_LIM +: 3];
	wire [15:0] cur_ofs = ofs_r[dir_r];
	wire neg_pol = cur_ofs[OF_POL];
	wire [7:0] early_mag = {1'b0, cur_ofs[OF_EARLY +: 7]};
	wire [7:0] early_ofs = neg_pol ? 8'(-early_mag) : early_mag;
	wire [7:0] ret_ofs = cur_ofs[OF_RET +: 8];
	wire lvl = s2_r[dir_r] ^ neg_pol;
	wire rise = lvl && !lvl_q_r;
	wire fall = !lvl && lvl_q_r;
	wire [5:0] wave_n = wave_r + 6'h01;
	wire [15:0] ws_word = ws_r[hidx_r[2:1]];
	wire [5:0] wsel = hidx_r[0] ? ws_word[WS_HI +: 6] : ws_word[5:0];
	wire hit_now = rise && hidx_r < nh && wave_n == wsel;
	wire listen = st == S_EARLY || st == S_T1 || st == S_WAVES;
	wire tmo = listen && {1'b0, el_r[31:16]} >= lim;
	wire [31:0] el_n = el_r + FX_STEP;
	wire all_in = hidx_r == nh && t2done_r;
	// Shared serial divider: average, then t1/t2, then t2/t_ideal.
	wire [31:0] ideal_fx = 32'(launch_r[LC_IDEAL +: 8] * FX_STEP);
	wire [DIV_W-1:0] ld_num = (job_r == 2'h0) ? DIV_W'(sum_r) :
		(job_r == 2'h1) ? {1'b0, t1_r, 7'h0} : {1'b0, t2_r, 7'h0};
	wire [31:0] ld_den = (job_r == 2'h0) ? {29'h0, nh} : (job_r == 2'h1) ? t2_r : ideal_fx;
	wire [32:0] rem_w = {rem_r, num_r[DIV_W-1]};
	wire ge = rem_w >= {1'b0, den_r};
	wire [32:0] rem_s = ge ? rem_w - {1'b0, den_r} : rem_w;
	wire [7:0] qsat = (|num_r[DIV_W-1:8]) ? 8'hff : num_r[7:0];
	wire commit = st == S_COMMIT;
	wire tof_done = commit && (!diff_r || dir_r);

	// ----------------------------------------------------------------
	// Flight-time sequence
	// ----------------------------------------------------------------
	// Launch, listen, measure widths and hits, then divide and commit.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			st <= S_IDLE;
			{dir_r, diff_r, err_r, uperr_r, lvl_q_r, t2on_r, t2done_r, dld_r} <= 8'h00;
			{el_r, t1_r, t2_r, avg_r, den_r, rem_r} <= '0;
			{sum_r, wave_r, dcnt_r, hidx_r, job_r, num_r, r1_r, r2_r} <= '0;
			for (int i = 0; i < HITS; i++) sh_hit_r[i] <= '0;
		end else begin
			lvl_q_r <= lvl;
			el_r <= el_n;
			unique case (st)
				S_IDLE: if (tof_go) begin
					st <= S_DELAY;
					dir_r <= cmd == CMD_DN;
					diff_r <= cmd == CMD_DIFF;
					uperr_r <= 1'b0;
					el_r <= '0;
				end
				S_DELAY: begin
					{err_r, t2on_r, t2done_r, hidx_r, wave_r, sum_r, t1_r, t2_r} <= '0;
					for (int i = 0; i < HITS; i++) sh_hit_r[i] <= '0;
					if (el_r[31:16] >= {8'h0, launch_r[LC_DLY +: 8]}) st <= S_EARLY;
				end
				S_EARLY: if (rise) st <= S_T1;
				S_T1: begin
					if (lvl) t1_r <= t1_r + FX_STEP;
					if (fall) st <= S_WAVES;
				end
				S_WAVES: begin
					if (rise) wave_r <= wave_n;
					if (rise && wave_n == t2sel && !t2done_r) t2on_r <= 1'b1;
					if (t2on_r && lvl) t2_r <= t2_r + FX_STEP;
					if (t2on_r && fall) begin
						t2on_r <= 1'b0;
						t2done_r <= 1'b1;
					end
					if (hit_now) begin
						sh_hit_r[hidx_r] <= el_r;
						sum_r <= sum_r + {3'h0, el_r};
						hidx_r <= hidx_r + 3'h1;
					end
					if (all_in) begin
						st <= S_DIV;
						job_r <= 2'h0;
						dld_r <= 1'b1;
					end
				end
				S_DIV: if (dld_r) begin
					num_r <= ld_num;
					den_r <= ld_den;
					rem_r <= '0;
					dcnt_r <= 6'(DIV_W);
					dld_r <= 1'b0;
				end else if (dcnt_r != 6'h0) begin
					num_r <= {num_r[DIV_W-2:0], ge};
					rem_r <= rem_s[31:0];
					dcnt_r <= dcnt_r - 6'h01;
				end else begin
					dld_r <= 1'b1;
					job_r <= job_r + 2'h1;
					if (job_r == 2'h0) avg_r <= num_r[31:0];
					if (job_r == 2'h1) r1_r <= qsat;
					if (job_r == 2'h2) begin
						r2_r <= qsat;
						st <= S_COMMIT;
					end
				end
				S_COMMIT: if (diff_r && !dir_r) begin
					st <= S_DELAY;
					dir_r <= 1'b1;
					uperr_r <= err_r;
					el_r <= '0;
				end else st <= S_IDLE;
			endcase
			// A timeout cuts the measurement short and marks it bad.
			if (tmo) begin
				err_r <= 1'b1;
				st <= S_COMMIT;
			end
		end
	end

	// ----------------------------------------------------------------
	// Result registers: flight results written in the commit cycle, port words when a temperature run ends
	// ----------------------------------------------------------------
	logic [31:0] hit_r [0:2*HITS-1];
	logic [31:0] mean_r [0:1];
	logic [15:0] ratio_r [0:1];
	logic [31:0] delta_r, dmean_r;
	logic [31:0] port_r [0:3];
	wire bad = err_r || uperr_r;
	wire [31:0] delta_w = mean_r[0] - avg_r;
	wire [31:0] dm_w = dmean_r + 32'($signed(delta_w - dmean_r) >>> DM_SHIFT);

	// Whole and fraction words change together so a read never mixes old and new.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			{delta_r, dmean_r} <= '0;
			for (int i = 0; i < 2 * HITS; i++) hit_r[i] <= '0;
			for (int i = 0; i < 2; i++) mean_r[i] <= '0;
			for (int i = 0; i < 2; i++) ratio_r[i] <= RST16;
		end else if (commit) begin
			for (int i = 0; i < HITS; i++)
				hit_r[(dir_r ? HITS : 0) + i] <= err_r ? {ALL1, ALL1} : sh_hit_r[i];
			mean_r[dir_r] <= err_r ? {ALL1, ALL1} : avg_r;
			ratio_r[dir_r] <= err_r ? ALL1 : {r1_r, r2_r};
			if (diff_r && dir_r) begin
				delta_r <= bad ? {DIFF_ERR, ALL1} : delta_w;
				if (!bad) dmean_r <= dm_w;
			end
		end
	end

	// ----------------------------------------------------------------
	// Temperature sequence
	// ----------------------------------------------------------------
	logic [3:0] tk_r;
	logic [15:0] tcnt_r;
	logic [31:0] tel_r;
	logic [31:0] tsh_r [0:3];
	wire [2:0] dum = tcfg_r[TC_DUM +: 3];
	wire [2:0] np = {1'b0, tcfg_r[TC_PORT +: 2]} + 3'h1;
	wire [3:0] total = {1'b0, dum} + {np, 1'b0};
	wire is_dum = tk_r < {1'b0, dum};
	wire [3:0] tj = tk_r - {1'b0, dum};
	wire [1:0] prt = tj[2:1];
	wire real_m = tj[0];
	wire [15:0] ivl = 16'(({14'h0, tcfg_r[TC_IVL +: 2]} + 16'h1) * 16'(PORT_BASE_CYC));
	wire cap_low = !s2_r[2];
	wire topen = tst == T_DIS && !cap_low && tcnt_r >= ivl - 16'h2;
	wire tend = tst == T_GAP && tcnt_r == ivl - 16'h1;
	wire tdone = tend && tk_r == total - 4'h1;

	// Charge, discharge through one port, then wait out the interval.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			tst <= T_IDLE;
			{tk_r, tcnt_r, tel_r} <= '0;
			for (int i = 0; i < 4; i++) {tsh_r[i], port_r[i]} <= '0;
		end else begin
			tcnt_r <= tcnt_r + 16'h1;
			unique case (tst)
				T_IDLE: if (cmd_wr && cmd == CMD_TEMP) begin
					tst <= T_CHG;
					{tk_r, tcnt_r} <= '0;
				end
				T_CHG: if (tcnt_r == 16'(CHARGE_CYC - 1)) begin
					tst <= T_DIS;
					tel_r <= '0;
				end
				T_DIS: begin
					tel_r <= tel_r + FX_STEP;
					if (cap_low) begin
						if (!is_dum && real_m) tsh_r[prt] <= tel_r;
						tst <= T_GAP;
					end else if (topen) begin
						if (!is_dum) tsh_r[prt] <= {ALL1, ALL1};
						tst <= T_GAP;
					end
				end
				T_GAP: if (tend) begin
					tcnt_r <= '0;
					tk_r <= tk_r + 4'h1;
					tst <= tdone ? T_IDLE : T_CHG;
				end
			endcase
			if (tdone) begin
				for (int i = 0; i < 4; i++)
					if (3'(i) < np) port_r[i] <= tsh_r[i];
			end
		end
	end

	// ----------------------------------------------------------------
	// Status, interrupt, pins and read port
	// ----------------------------------------------------------------
	wire st_clr = i_rd && i_addr == A_INTST;
	wire [2:0] st_set = {tdone, tmo || topen, tof_done};
	// A new event in the clearing read cycle survives the clear.
	assign st_nxt = (st_clr ? 3'h0 : st_r) | st_set;
	wire [6:0] pa = i_addr[7:1];
	wire hit_a = (i_addr[7:4] == A_UPHIT[7:4] || i_addr[7:4] == A_DNHIT[7:4]) && i_addr[3:1] < 3'(HITS);
	wire [3:0] hit_ix = (i_addr[7:4] == A_DNHIT[7:4] ? 4'(HITS) : 4'h0) + {1'b0, i_addr[3:1]};
	wire [31:0] w32 = hit_a ? hit_r[hit_ix] : pa == A_MEAN[7:1] ? mean_r[0] :
		pa == A_MEAN[7:1] + 7'h1 ? mean_r[1] : pa == A_DELTA[7:1] ? delta_r :
		pa == A_DMEAN[7:1] ? dmean_r : pa[6:2] == A_PORT[7:3] ? port_r[pa[1:0]] : 32'h0;
	wire pair_a = hit_a || pa == A_MEAN[7:1] || pa == A_MEAN[7:1] + 7'h1 || pa == A_DELTA[7:1] ||
		pa == A_DMEAN[7:1] || pa[6:2] == A_PORT[7:3];
	wire [15:0] w16 = i_addr == A_HITCFG ? hit_cfg_r : i_addr == A_WSA ? ws_r[0] :
		i_addr == A_WSB ? ws_r[1] : i_addr == A_WSC ? ws_r[2] : i_addr == A_OFSU ? ofs_r[0] :
		i_addr == A_OFSD ? ofs_r[1] : i_addr == A_LAUNCH ? launch_r : i_addr == A_TEMPCFG ? tcfg_r :
		i_addr == A_INTEN ? {13'h0, inten_r} : i_addr == A_INTST ? {13'h0, st_r} :
		i_addr == A_RATIO ? ratio_r[0] : i_addr == A_RATIO + 8'h1 ? ratio_r[1] : 16'h0;
	wire [15:0] rd_w = pair_a ? (i_addr[0] ? w32[15:0] : w32[31:16]) : w16;

	// Every output is registered; the interrupt is an active-low, enabled OR of flags.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			st_r <= 3'h0;
			o_int_n <= 1'b1;
			o_rdata <= 16'h0;
			{o_launch_go, o_launch_dn, o_cmp_en_up, o_cmp_en_dn, o_cap_o, o_emul_en} <= 6'h0;
			o_cap_oe_n <= 1'b1;
			o_cmp_offset <= 8'h0;
			o_probe_o <= 4'h0;
		end else begin
			st_r <= st_nxt;
			o_int_n <= ~|(st_nxt & inten_r);
			o_rdata <= i_rd ? rd_w : 16'h0;
			o_launch_go <= tof_go || (commit && diff_r && !dir_r);
			o_launch_dn <= dir_r;
			o_cmp_en_up <= listen && !dir_r;
			o_cmp_en_dn <= listen && dir_r;
			o_cmp_offset <= st == S_EARLY ? early_ofs : ret_ofs;
			o_cap_o <= tst == T_CHG;
			o_cap_oe_n <= tst != T_CHG;
			o_emul_en <= tst == T_DIS && is_dum;
			o_probe_o <= 4'h0;
		end
	end

	// One open-drain pull-down per probe port.
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_probe
			always_ff @(posedge i_clk) begin
				if (i_srst) o_probe_oe_n[g] <= 1'b1;
				else o_probe_oe_n[g] <= !(tst == T_DIS && !is_dum && prt == 2'(g));
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);
	property p_gate; $rose(o_cmp_en_up || o_cmp_en_dn) |-> $past(el_r[31:16], 2) >= {8'h0, launch_r[LC_DLY +: 8]}; endproperty
	a_gate: assert property (p_gate) else $error("comparator enabled early");
	property p_early; st == S_EARLY |=> o_cmp_offset == $past(early_ofs); endproperty
	a_early: assert property (p_early) else $error("early offset wrong");
	property p_ret; (st == S_T1 || st == S_WAVES) |=> o_cmp_offset == $past(ret_ofs); endproperty
	a_ret: assert property (p_ret) else $error("return offset wrong");
	property p_int; tof_done && inten_r[IB_FLIGHT] |=> !o_int_n ##1 (!o_int_n || $past(st_clr)); endproperty
	a_int: assert property (p_int) else $error("interrupt not held");
	property p_err; commit && err_r |=> hit_r[$past(dir_r) ? HITS : 0] == {ALL1, ALL1}; endproperty
	a_err: assert property (p_err) else $error("error result not all ones");
	property p_dm; commit && diff_r && dir_r && bad |=> $stable(dmean_r); endproperty
	a_dm: assert property (p_dm) else $error("errored run averaged");
	property p_tmo; tmo |=> st_r[IB_TOUT] ##1 st == S_IDLE || st == S_DELAY; endproperty
	a_tmo: assert property (p_tmo) else $error("timeout not flagged");
	property p_chg; tst == T_CHG |=> !o_cap_oe_n && o_cap_o; endproperty
	a_chg: assert property (p_chg) else $error("capacitor not charged");
	property p_ivl; tst != T_IDLE |-> tcnt_r < ivl; endproperty
	a_ivl: assert property (p_ivl) else $error("port interval overrun");
	property p_tdone; tdone |=> st_r[IB_THERM] && tst == T_IDLE; endproperty
	a_tdone: assert property (p_tdone) else $error("thermal done missing");
	c_diff: cover property (tof_done && diff_r && !bad);
	c_tmo: cover property (tmo);
	c_temp: cover property (tdone && tcfg_r[TC_PORT +: 2] == 2'h3);
endmodule

// *** flt_far_model.sv ***
// Far-side model: two receive comparators and the RTD discharge path.
// Assumes one clock shared with the sequencer and its port directions.
`timescale 1ns/10ps
module flt_far_model (
	// Clock and bench control
	input wire logic i_clk,
	input wire logic i_quiet_dn,
	// Sequencer side
	input wire logic i_cmp_en_up,
	input wire logic i_cmp_en_dn,
	input wire logic i_cap_o,
	input wire logic i_cap_oe_n,
	input wire logic [3:0] i_probe_oe_n,
	input wire logic i_emul_en,
	// Comparator outputs
	output logic o_stop_up,
	output logic o_stop_dn,
	output logic o_cap_cmp
);
	logic [3:0] ph_r = 4'h0;
	logic [5:0] rc_r = 6'h00;
	wire dis = ~&i_probe_oe_n | i_emul_en;
	// Waves of 16 cycles start low once a receiver is enabled, so wave 0 is never cut short.
	always_ff @(posedge i_clk) begin
		ph_r <= (i_cmp_en_up | i_cmp_en_dn) ? ph_r + 4'h1 : 4'h0;
	end
	assign o_stop_up = i_cmp_en_up & ph_r[3];
	assign o_stop_dn = i_cmp_en_dn & ~i_quiet_dn & ph_r[3];
	// Capacitor charged by the pin driver, bled by a probe or the emulation resistor.
	always_ff @(posedge i_clk) begin
		if (!i_cap_oe_n && i_cap_o) begin
			rc_r <= 6'h28;
		end else if (dis && rc_r != 6'h00) begin
			rc_r <= rc_r - 6'h01;
		end
	end
	assign o_cap_cmp = (rc_r != 6'h00);
endmodule

// *** tb.sv ***
// Self-checking bench for the flight-time and temperature sequencer.
// Assumes the far-side model supplies every comparator input.
`timescale 1ns/10ps
module tb import flt_pkg::*;;
	logic i_clk, i_srst, i_wr, i_rd, quiet_dn, stop_up, stop_dn, cap_cmp;
	logic [7:0] i_addr, off_first, off_last;
	logic [15:0] i_wdata, rdata, d, h0, h1, m;
	logic launch_go, launch_dn, en_up, en_dn, cap_o, cap_oe_n, emul, int_n, emul_q, en_q, chg_q;
	logic [7:0] offs;
	logic [3:0] probe_o, probe_oe_n, pq;
	int n_fail = 0, samples_checked = 0, n_emul, falls[4], k, int_seen, n_launch, n_chg, dn_seen;
	flt_seq flt_seq_inst (.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(rdata), .i_stop_up(stop_up), .i_stop_dn(stop_dn), .o_launch_go(launch_go),
		.o_launch_dn(launch_dn), .o_cmp_en_up(en_up), .o_cmp_en_dn(en_dn), .o_cmp_offset(offs),
		.i_cap_cmp(cap_cmp), .o_cap_o(cap_o), .o_cap_oe_n(cap_oe_n), .o_probe_o(probe_o),
		.o_probe_oe_n(probe_oe_n), .o_emul_en(emul), .o_int_n(int_n));
	flt_far_model flt_far_model_inst (.i_clk(i_clk), .i_quiet_dn(quiet_dn), .i_cmp_en_up(en_up),
		.i_cmp_en_dn(en_dn), .i_cap_o(cap_o), .i_cap_oe_n(cap_oe_n), .i_probe_oe_n(probe_oe_n),
		.i_emul_en(emul), .o_stop_up(stop_up), .o_stop_dn(stop_dn), .o_cap_cmp(cap_cmp));
	// 50 MHz clock.
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	// Pin watcher: counts discharge phases and notes the threshold before and after wave 0.
	always @(posedge i_clk) begin
		if (int_n === 1'b0) int_seen = 1;
		if (emul && !emul_q) n_emul++;
		if (cap_o && !chg_q) n_chg++;
		if (launch_go) n_launch++;
		if (en_dn) dn_seen = 1;
		chg_q = cap_o;
		for (int p = 0; p < 4; p++) if (!probe_oe_n[p] && pq[p]) falls[p]++;
		if (en_up && !en_q) off_first = offs;
		if (en_up) off_last = offs;
		emul_q = emul;
		pq = probe_oe_n;
		en_q = en_up;
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= v;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	// The answer stands only in the cycle after the read edge, so it is taken there.
	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic wait_int();
		for (k = 0; k < 40000 && int_n !== 1'b0; k++) @(posedge i_clk);
	endtask
	task automatic run_temp(input logic [15:0] cfg, input int nd, input int np);
		n_emul = 0;
		n_chg = 0;
		falls = '{0, 0, 0, 0};
		wr(A_TEMPCFG, cfg);
		wr(A_INTEN, 16'h0004);
		wr(A_CMD, {13'h0, CMD_TEMP});
		wait_int();
		rd(A_INTST, d);
		chk("thermal_flag", 16'h0004, d);
		chk("dummies", 16'(nd), 16'(n_emul));
		chk("charges", 16'(nd + 2 * np), 16'(n_chg));
		for (int p = 0; p < 4; p++) chk("port_steps", (p < np) ? 16'h2 : 16'h0, 16'(falls[p]));
		rd(A_PORT, d);
		chk("port_time", 16'h1, {15'h0, d != 16'hffff && d != 16'h0});
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Watchdog sized well above the roughly 40k cycles the tests need.
	initial begin
		repeat (90000) @(posedge i_clk);
		n_fail++;
		final_report();
	end
	// Main sequence.
	initial begin
		i_srst = 1'b1;
		i_addr = 8'h00;
		i_wdata = 16'h0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		quiet_dn = 1'b0;
		repeat (10) @(posedge i_clk);
		i_srst <= 1'b0;
		@(posedge i_clk);
		#1 chk("int_n_reset", 16'h1, {15'h0, int_n});
		rd(8'hff, d);
		chk("unmapped", 16'h0, d);
		wr(A_HITCFG, 16'h0082);
		wr(A_WSA, 16'h0301);
		wr(A_OFSU, 16'hf020);
		wr(A_OFSD, 16'hf020);
		wr(A_LAUNCH, 16'h0804);
		wr(A_INTEN, 16'h0000);
		int_seen = 0;
		wr(A_CMD, {13'h0, CMD_UP});
		d = 16'h0;
		for (int j = 0; j < 2000 && d === 16'h0; j++) rd(A_INTST, d);
		chk("flight_flag", 16'h0001, d);
		chk("int_masked", 16'h0, 16'(int_seen));
		chk("early_thr", 16'h0020, {8'h0, off_first});
		chk("return_thr", 16'h00f0, {8'h0, off_last});
		rd(A_UPHIT, h0);
		rd(A_UPHIT + 8'h2, h1);
		rd(A_MEAN, m);
		chk("hit_order", 16'h1, {15'h0, h1 > h0 && h0 != 16'h0});
		chk("mean_span", 16'h1, {15'h0, m >= h0 && m <= h1});
		// Downstream run with the flight interrupt enabled: the pin must hold until status is read.
		wr(A_INTEN, 16'h0001);
		wr(A_CMD, {13'h0, CMD_DN});
		wait_int();
		repeat (4) @(posedge i_clk);
		#1 chk("int_held", 16'h0, {15'h0, int_n});
		rd(A_INTST, d);
		chk("dn_flag", 16'h0001, d);
		chk("dn_int_clear", 16'h1, {15'h0, int_n});
		rd(A_DNHIT + 8'h2, h1);
		chk("dn_hit", 16'h1, {15'h0, h1 != 16'h0 && h1 != 16'hffff});
		quiet_dn <= 1'b1;
		wr(A_INTEN, 16'h0002);
		n_launch = 0;
		dn_seen = 0;
		wr(A_CMD, {13'h0, CMD_DIFF});
		wait_int();
		rd(A_INTST, d);
		chk("tout_flag", 16'h0002, d & 16'h0002);
		chk("launches", 16'h2, 16'(n_launch));
		chk("dn_listen", 16'h1, 16'(dn_seen));
		chk("launch_dir", 16'h1, {15'h0, launch_dn});
		rd(A_DNHIT, d);
		chk("dn_hit_err", 16'hffff, d);
		rd(A_MEAN + 8'h2, d);
		chk("dn_mean_err", 16'hffff, d);
		rd(A_DELTA, d);
		chk("delta_whole", 16'h7fff, d);
		rd(A_DELTA + 8'h1, d);
		chk("delta_frac", 16'hffff, d);
		rd(A_INTST, d);
		chk("status_clear", 16'h0, d);
		chk("int_released", 16'h1, {15'h0, int_n});
		run_temp(16'h0004, 1, 1);
		run_temp(16'h0003, 0, 4);
		final_report();
	end
endmodule
